/* hdl/sram_burst_pkg.sv */
/*
 * Shared constants for the burst SRAM address front end: widths, lane layout,
 * burst counter steps and order, write buffer depth, reset values and the access state type.
 * Assumes a single 100 MHz clock and the 64K x 36 organisation.
 */
package sram_burst_pkg;
	localparam int ADDR_W = 16; // Word address width
	localparam int LANES = 4; // Byte lanes on the data bus
	localparam int LANE_W = 8; // Data bits per lane
	localparam int PAR_BASE = LANES * LANE_W; // Parity bits sit above the data bytes
	localparam int DATA_W = PAR_BASE + LANES; // Data plus one parity bit per lane
	localparam int WCMD_W = LANES + ADDR_W + DATA_W; // Buffered write: enables, address, data
	localparam int WBUF_DEPTH = 16; // Write buffer depth in words
	localparam logic [1:0] BEAT_FIRST = 2'h0; // Burst beat count after a load
	localparam logic [1:0] BEAT_STEP = 2'h1; // One advance of the 2-bit counter
	localparam logic ORDER_LINEAR = 1'h0; // Burst order input low
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000; // Address after reset
	localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000; // Data registers after reset

	// Access state of the front end
	typedef enum logic [1:0] {
		idle_s,
		burst_s,
		pdown_s
	} access_state_t;

	// Low two address bits for a beat: linear adds, interleaved XORs
	function automatic logic [1:0] beat_low(input logic [1:0] start, input logic [1:0] beat,
		input logic order);
		beat_low = (order == ORDER_LINEAR) ? 2'(start + beat) : (start ^ beat);
	endfunction : beat_low
endpackage : sram_burst_pkg

/* hdl/wbuf_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides and registered output stage.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module wbuf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH); // Pointer width
	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage array
	logic [PW-1:0] wp_q; // Write pointer
	logic [PW-1:0] rp_q; // Read pointer
	logic [PW:0] count_q; // Words held in the array
	logic push; // Word accepted
	logic pop; // Word moved to the output stage

	assign push = in_valid_i && in_ready_o;
	assign pop = (count_q != '0) && (!out_valid_o || out_ready_i);

	// Array write; no reset so it maps onto RAM
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_q[wp_q] <= in_data_i;
		end
	end

	// Pointers, count and a registered full flag
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_q <= '0;
			rp_q <= '0;
			count_q <= '0;
			in_ready_o <= 1'b1;
		end else begin
			if (push) begin
				wp_q <= PW'(wp_q + 1'b1);
			end
			if (pop) begin
				rp_q <= PW'(rp_q + 1'b1);
			end
			count_q <= (PW + 1)'(count_q + push - pop);
			in_ready_o <= ((PW + 1)'(count_q + push - pop)) != (PW + 1)'(DEPTH);
		end
	end

	// Output stage keeps the drain side registered
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o <= mem_q[rp_q];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule : wbuf_fifo

/* hdl/sram_addr_ctrl.sv */
/*
 * Address-start and burst sequencing front end of a pipelined burst SRAM,
 * 64K x 36 organisation, with a write buffer toward the array.
 * Assumes all pins are synchronous to core_clk_i; the array answers a read
 * one cycle after mem_rd_o and drains writes through mem_w*.
 */
// Contract
// - Either strobe low aborts burst, loads address (processor strobe only with primary select low)
// - Processor strobe with enables reads new address
// - Processor strobe start ignores write controls
// - Processor strobe ignored when primary select high
// - Processor strobe, secondary enables off: power-down
// - Controller strobe, select low: read or write
// - Controller strobe, select high: deselect power-down
// - Order input low linear, high interleaved
// - Data bus split into four byte lanes
// - One parity bit per lane
// - Interleaved beats XOR low bits 01,10,11
// - Linear beats add one, wrap modulo four
// - Advance low steps, high holds address
// - Write if global or gate plus lane
// - Enables sampled only on address loads
`timescale 1ns/1ps
module sram_addr_ctrl (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [sram_burst_pkg::ADDR_W-1:0] addr_i,
	input wire logic proc_addr_strobe_n_i,
	input wire logic ctrl_addr_strobe_n_i,
	input wire logic chip_sel_n_i,
	input wire logic chip_sel_hi_i,
	input wire logic chip_sel_lo2_n_i,
	input wire logic burst_advance_n_i,
	input wire logic burst_order_i,
	input wire logic global_write_n_i,
	input wire logic byte_write_gate_n_i,
	input wire logic lane0_write_n_i,
	input wire logic lane1_write_n_i,
	input wire logic lane2_write_n_i,
	input wire logic lane3_write_n_i,
	input wire logic [sram_burst_pkg::LANE_W-1:0] lane0_in_i,
	input wire logic [sram_burst_pkg::LANE_W-1:0] lane1_in_i,
	input wire logic [sram_burst_pkg::LANE_W-1:0] lane2_in_i,
	input wire logic [sram_burst_pkg::LANE_W-1:0] lane3_in_i,
	input wire logic lane0_parity_in_i,
	input wire logic lane1_parity_in_i,
	input wire logic lane2_parity_in_i,
	input wire logic lane3_parity_in_i,
	output logic [sram_burst_pkg::LANE_W-1:0] lane0_out_o,
	output logic [sram_burst_pkg::LANE_W-1:0] lane1_out_o,
	output logic [sram_burst_pkg::LANE_W-1:0] lane2_out_o,
	output logic [sram_burst_pkg::LANE_W-1:0] lane3_out_o,
	output logic lane0_parity_out_o,
	output logic lane1_parity_out_o,
	output logic lane2_parity_out_o,
	output logic lane3_parity_out_o,
	output logic data_oe_o,
	output logic powerdown_o,
	output logic [sram_burst_pkg::ADDR_W-1:0] mem_addr_o,
	output logic mem_rd_o,
	input wire logic [sram_burst_pkg::DATA_W-1:0] mem_rdata_i,
	output logic wbuf_ready_o,
	output logic mem_wvalid_o,
	input wire logic mem_wready_i,
	output logic [sram_burst_pkg::WCMD_W-1:0] mem_wcmd_o
);
	import sram_burst_pkg::*;

	access_state_t state_q; // Idle, bursting or powered down
	logic [ADDR_W-1:0] base_q; // Externally loaded start address
	logic [1:0] beat_q; // Burst counter, two bits so it wraps by itself
	logic rd_pipe_q; // Read issued last cycle, data due now
	logic [DATA_W-1:0] rdata_q; // Read data driven onto the lanes
	logic [LANES-1:0] lane_wr; // Lanes picked for a write
	logic is_write; // Cycle decodes as a write
	logic proc_start; // Processor strobe that counts
	logic load; // New external address this cycle
	logic enabled; // All three enables active
	logic cont; // Burst continuation cycle
	logic [1:0] beat_d; // Counter after this cycle
	logic [ADDR_W-1:0] acc_addr; // Address of this cycle's access
	logic acc_rd; // Read performed this cycle
	logic acc_wr; // Write performed this cycle
	logic [DATA_W-1:0] wdata; // Lanes gathered into one word

	// Decode of the strobes and enables
	always_comb begin
		proc_start = !proc_addr_strobe_n_i && !chip_sel_n_i;
		load = proc_start || !ctrl_addr_strobe_n_i;
		enabled = !chip_sel_n_i && chip_sel_hi_i && !chip_sel_lo2_n_i;
		cont = !load && (state_q == burst_s);
		lane_wr = {!lane3_write_n_i, !lane2_write_n_i, !lane1_write_n_i, !lane0_write_n_i};
		// Global write covers every lane; otherwise the gate qualifies lanes
		if (!global_write_n_i) begin
			lane_wr = '1;
		end else if (byte_write_gate_n_i) begin
			lane_wr = '0;
		end
		is_write = lane_wr != '0;
	end

	// Counter and access decode for this cycle
	always_comb begin
		beat_d = beat_q;
		acc_addr = {base_q[ADDR_W-1:2], beat_low(base_q[1:0], beat_q, burst_order_i)};
		acc_rd = 1'b0;
		acc_wr = 1'b0;
		if (load) begin
			beat_d = BEAT_FIRST;
			acc_addr = addr_i;
			if (proc_start) begin
				acc_rd = enabled;
			end else begin
				acc_rd = enabled && !is_write;
				acc_wr = enabled && is_write;
			end
		end else if (cont) begin
			// Advance low steps; the 2-bit counter keeps upper bits fixed
			if (!burst_advance_n_i) begin
				beat_d = 2'(beat_q + BEAT_STEP);
			end
			acc_addr = {base_q[ADDR_W-1:2], beat_low(base_q[1:0], beat_d, burst_order_i)};
			acc_rd = !is_write;
			acc_wr = is_write;
		end
	end

	// Access state: loads qualify enables, continuation ignores them
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= idle_s;
		end else begin
			case (state_q)
				idle_s, burst_s, pdown_s: begin
					if (load) begin
						state_q <= enabled ? burst_s : pdown_s;
					end
				end
				default: begin
					state_q <= idle_s;
				end
			endcase
		end
	end

	// Start address and burst counter
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			base_q <= ADDR_RST;
			beat_q <= BEAT_FIRST;
		end else begin
			if (load) begin
				base_q <= addr_i;
			end
			beat_q <= beat_d;
		end
	end

	// Array-side read request and address, plus power-down flag
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_addr_o <= ADDR_RST;
			mem_rd_o <= 1'b0;
			powerdown_o <= 1'b1;
		end else begin
			mem_addr_o <= acc_addr;
			mem_rd_o <= acc_rd;
			if (load) begin
				powerdown_o <= !enabled;
			end
		end
	end

	// Read data returns one cycle after the request and drives the lanes
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_pipe_q <= 1'b0;
			rdata_q <= DATA_RST;
			data_oe_o <= 1'b0;
		end else begin
			rd_pipe_q <= mem_rd_o;
			data_oe_o <= rd_pipe_q;
			if (rd_pipe_q) begin
				rdata_q <= mem_rdata_i;
			end
		end
	end

	// Lane and parity slices of the read word
	assign lane0_out_o = rdata_q[0*LANE_W +: LANE_W];
	assign lane1_out_o = rdata_q[1*LANE_W +: LANE_W];
	assign lane2_out_o = rdata_q[2*LANE_W +: LANE_W];
	assign lane3_out_o = rdata_q[3*LANE_W +: LANE_W];
	assign lane0_parity_out_o = rdata_q[PAR_BASE + 0];
	assign lane1_parity_out_o = rdata_q[PAR_BASE + 1];
	assign lane2_parity_out_o = rdata_q[PAR_BASE + 2];
	assign lane3_parity_out_o = rdata_q[PAR_BASE + 3];
	assign wdata = {lane3_parity_in_i, lane2_parity_in_i, lane1_parity_in_i, lane0_parity_in_i,
		lane3_in_i, lane2_in_i, lane1_in_i, lane0_in_i};

	// Writes are buffered; a full buffer drops the write, so watch wbuf_ready_o
	wbuf_fifo #(
		.WIDTH(WCMD_W),
		.DEPTH(WBUF_DEPTH)
	) u_wbuf (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(acc_wr),
		.in_ready_o(wbuf_ready_o),
		.in_data_i({lane_wr, acc_addr, wdata}),
		.out_valid_o(mem_wvalid_o),
		.out_ready_i(mem_wready_i),
		.out_data_o(mem_wcmd_o)
	);

	a_proc_read_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(proc_start && enabled) |=> (mem_rd_o && mem_addr_o == $past(addr_i))) else $error("read start missed");
	a_proc_no_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		proc_start |-> !acc_wr) else $error("write on processor start");
	a_proc_strobe_ignored: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(chip_sel_n_i && ctrl_addr_strobe_n_i) |=> $stable(base_q)) else $error("ignored strobe loaded");
	a_proc_pdown_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(proc_start && (!chip_sel_hi_i || chip_sel_lo2_n_i)) |=> (powerdown_o && !mem_rd_o))
		else $error("no power-down");
	a_ctrl_access: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(!ctrl_addr_strobe_n_i && !proc_start && enabled && !is_write) |=> mem_rd_o ##1 rd_pipe_q)
		else $error("controller read missed");
	a_ctrl_deselect: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(!ctrl_addr_strobe_n_i && chip_sel_n_i) |=> (powerdown_o && state_q == pdown_s))
		else $error("no deselect");
	a_linear_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cont && !burst_advance_n_i && burst_order_i == ORDER_LINEAR)
		|=> mem_addr_o[1:0] == 2'($past(base_q[1:0]) + $past(beat_q) + 2'h1)) else $error("linear step wrong");
	a_interleave_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cont && !burst_advance_n_i && burst_order_i != ORDER_LINEAR)
		|=> mem_addr_o[1:0] == ($past(base_q[1:0]) ^ 2'($past(beat_q) + 2'h1))) else $error("interleave wrong");
	a_advance_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cont && burst_advance_n_i) ##1 (cont && burst_advance_n_i) |=> $stable(mem_addr_o))
		else $error("address moved on hold");
	a_group_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		cont |=> mem_addr_o[ADDR_W-1:2] == $past(base_q[ADDR_W-1:2])) else $error("burst left group");
	a_write_decode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(cont && global_write_n_i && byte_write_gate_n_i) |=> mem_rd_o) else $error("gate ignored");
endmodule : sram_addr_ctrl

/* tb/sram_array_model.sv */
/*
 * Array model behind the front end: answers a read one cycle after the
 * request and stores buffered writes lane by lane; the write port can stall.
 * Assumes the design's clock and the 64K x 36 word layout.
 */
`timescale 1ns/1ps
module sram_array_model (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic mem_rd_i,
	output logic [35:0] mem_rdata_o,
	input wire logic mem_wvalid_i,
	output logic mem_wready_o,
	input wire logic [55:0] mem_wcmd_i,
	input wire logic stall_i
);
	logic [35:0] mem [65536]; // Word storage
	logic [65535:0] seen = '0; // Words written since start
	logic [35:0] w; // Word being merged
	// Unwritten words read as a pattern built from the address
	function automatic logic [35:0] base(input logic [15:0] a);
		base = seen[a] ? mem[a] : {4'ha, a, a};
	endfunction : base
	// Read answer; between reads the bus toggles so stale data never looks valid
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_rdata_o <= 36'h0;
			mem_wready_o <= 1'b1;
		end else begin
			mem_rdata_o <= mem_rd_i ? base(mem_addr_i) : ~mem_rdata_o;
			mem_wready_o <= !stall_i; // Registered so the stall lands on an edge
		end
	end
	// Lane-wise write merge, data and parity together
	always @(posedge core_clk_i) begin
		if (mem_wvalid_i && mem_wready_o) begin
			w = base(mem_wcmd_i[51:36]);
			for (int n = 0; n < 4; n++) if (mem_wcmd_i[52+n]) begin
				w[8*n+:8] = mem_wcmd_i[8*n+:8];
				w[32+n] = mem_wcmd_i[32+n];
			end
			mem[mem_wcmd_i[51:36]] <= w;
			seen[mem_wcmd_i[51:36]] <= 1'b1;
		end
	end
endmodule : sram_array_model

/* tb/testbench.sv */
/*
 * Pin-level bench for the burst SRAM front end: strobe, burst and write tests.
 * Assumes the array model answers behind the design and a 100 MHz clock.
 */
`timescale 1ns/1ps
module testbench;
	import sram_burst_pkg::*;
	logic core_clk_i = 0, rst_n_i = 0, stall = 0; // Clock, reset, array stall
	logic proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, chip_sel_n_i, chip_sel_hi_i, chip_sel_lo2_n_i;
	logic burst_advance_n_i, burst_order_i, global_write_n_i, byte_write_gate_n_i;
	logic lane0_write_n_i, lane1_write_n_i, lane2_write_n_i, lane3_write_n_i;
	logic [7:0] lane0_in_i, lane1_in_i, lane2_in_i, lane3_in_i, lane0_out_o, lane1_out_o, lane2_out_o, lane3_out_o;
	logic lane0_parity_in_i, lane1_parity_in_i, lane2_parity_in_i, lane3_parity_in_i;
	logic lane0_parity_out_o, lane1_parity_out_o, lane2_parity_out_o, lane3_parity_out_o;
	logic data_oe_o, powerdown_o, mem_rd_o, wbuf_ready_o, mem_wvalid_o, mem_wready_i;
	logic [15:0] addr_i, mem_addr_o, a, wa;
	logic [35:0] mem_rdata_i, d, wd;
	logic [55:0] mem_wcmd_o;
	int bad_count = 0, compares = 0, n;
	logic [2:0] pd_en [3] = '{3'b000, 3'b011, 3'b110}; // Enables that must power down
	logic [5:0] wr_t [4] = '{6'h1f, 6'h2d, 6'h2a, 6'h30}; // Write control codes
	logic [3:0] en_t [4] = '{4'hf, 4'h2, 4'h5, 4'h0}; // Lanes each code writes
	wire [35:0] rd = {lane3_parity_out_o, lane2_parity_out_o, lane1_parity_out_o, lane0_parity_out_o,
		lane3_out_o, lane2_out_o, lane1_out_o, lane0_out_o};
	assign {lane3_in_i, lane2_in_i, lane1_in_i, lane0_in_i} = d[31:0];
	assign {lane3_parity_in_i, lane2_parity_in_i, lane1_parity_in_i, lane0_parity_in_i} = d[35:32];
	// Every pin named, so a missing or renamed port shows up at elaboration
	sram_addr_ctrl u_dut (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.addr_i(addr_i),
		.proc_addr_strobe_n_i(proc_addr_strobe_n_i),
		.ctrl_addr_strobe_n_i(ctrl_addr_strobe_n_i),
		.chip_sel_n_i(chip_sel_n_i),
		.chip_sel_hi_i(chip_sel_hi_i),
		.chip_sel_lo2_n_i(chip_sel_lo2_n_i),
		.burst_advance_n_i(burst_advance_n_i),
		.burst_order_i(burst_order_i),
		.global_write_n_i(global_write_n_i),
		.byte_write_gate_n_i(byte_write_gate_n_i),
		.lane0_write_n_i(lane0_write_n_i), .lane1_write_n_i(lane1_write_n_i),
		.lane2_write_n_i(lane2_write_n_i), .lane3_write_n_i(lane3_write_n_i),
		.lane0_in_i(lane0_in_i), .lane1_in_i(lane1_in_i), .lane2_in_i(lane2_in_i), .lane3_in_i(lane3_in_i),
		.lane0_parity_in_i(lane0_parity_in_i), .lane1_parity_in_i(lane1_parity_in_i),
		.lane2_parity_in_i(lane2_parity_in_i), .lane3_parity_in_i(lane3_parity_in_i),
		.lane0_out_o(lane0_out_o), .lane1_out_o(lane1_out_o), .lane2_out_o(lane2_out_o), .lane3_out_o(lane3_out_o),
		.lane0_parity_out_o(lane0_parity_out_o), .lane1_parity_out_o(lane1_parity_out_o),
		.lane2_parity_out_o(lane2_parity_out_o), .lane3_parity_out_o(lane3_parity_out_o),
		.data_oe_o(data_oe_o),
		.powerdown_o(powerdown_o),
		.mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o),
		.mem_rdata_i(mem_rdata_i),
		.wbuf_ready_o(wbuf_ready_o),
		.mem_wvalid_o(mem_wvalid_o),
		.mem_wready_i(mem_wready_i),
		.mem_wcmd_o(mem_wcmd_o)
	);
	sram_array_model u_mem (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
		.mem_rdata_o(mem_rdata_i), .mem_wvalid_i(mem_wvalid_o), .mem_wready_o(mem_wready_i),
		.mem_wcmd_i(mem_wcmd_o), .stall_i(stall));
	always #5 core_clk_i = ~core_clk_i;
	// One bus cycle: inputs change on the edge, outputs read once settled
	task cyc(input logic p = 1, c = 1, v = 1, input logic [2:0] en = 3'b010,
		input logic [5:0] wr = 6'h3f, input logic [15:0] aa = 16'h0, input logic [35:0] dd = 36'h0);
		@(posedge core_clk_i);
		proc_addr_strobe_n_i <= p;
		ctrl_addr_strobe_n_i <= c;
		burst_advance_n_i <= v;
		{chip_sel_n_i, chip_sel_hi_i, chip_sel_lo2_n_i} <= en;
		{global_write_n_i, byte_write_gate_n_i, lane3_write_n_i, lane2_write_n_i, lane1_write_n_i, lane0_write_n_i} <= wr;
		addr_i <= aa;
		d <= dd;
		#1;
	endtask : cyc
	task chk(input string nm, input logic [55:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task report_and_stop;
		$display("Checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// Bounded wait; running out ends the run
	task automatic wait_sig(ref logic s, input logic v);
		for (int i = 0; i < 64 && s !== v; i++) cyc();
		if (s !== v) begin
			chk("wait", v, s);
			report_and_stop();
		end
	endtask : wait_sig
	// Expected word after a partial write
	function automatic logic [35:0] merge(input logic [35:0] o, nw, input logic [3:0] en);
		merge = o;
		for (int i = 0; i < LANES; i++) if (en[i]) begin
			merge[LANE_W*i+:LANE_W] = nw[LANE_W*i+:LANE_W];
			merge[PAR_BASE+i] = nw[PAR_BASE+i];
		end
	endfunction : merge
	// Single read started by the processor strobe, data two edges after the load
	task rd_chk(input logic [15:0] ra, input logic [35:0] e);
		cyc(.p(1'b0), .aa(ra));
		cyc();
		chk("rd_addr", ra, mem_addr_o);
		chk("rd_req", 1, mem_rd_o);
		cyc();
		cyc();
		chk("oe", 1, data_oe_o);
		chk("rd_data", e, rd);
	endtask : rd_chk
	initial begin
		burst_order_i <= ORDER_LINEAR;
		cyc(); // Idle pins from the first edge on, reset still held
		repeat (2) @(posedge core_clk_i);
		#1;
		chk("rst", 2'b11, {powerdown_o, wbuf_ready_o});
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd_chk(16'h1234, {4'ha, 16'h1234, 16'h1234});
		$display("test read done");
		// Every start offset in both orders, continuation with the select off
		for (int o = 0; o < 2; o++) for (int s = 0; s < 4; s++) begin
			@(posedge core_clk_i) burst_order_i <= o[0];
			a = {14'h2abc, s[1:0]};
			cyc(.p(1'b0), .aa(a));
			cyc(.v(1'b0), .en(3'b110));
			chk("burst0", a, mem_addr_o);
			for (int k = 1; k < 5; k++) begin
				cyc(.v(k == 4), .en(3'b110));
				chk("beat", {a[15:2], o ? a[1:0] ^ 2'(k) : 2'(a[1:0] + k)}, mem_addr_o);
			end
			cyc(.en(3'b110));
			chk("hold", a, mem_addr_o);
			chk("pd_cont", 0, powerdown_o);
		end
		cyc(.p(1'b0), .en(3'b110), .aa(16'hffff));
		cyc();
		cyc();
		chk("ignored", a, mem_addr_o);
		$display("test burst done");
		for (int i = 0; i < 3; i++) begin
			rd_chk(16'h0100, {4'ha, 16'h0100, 16'h0100});
			chk("awake", 0, powerdown_o);
			cyc(.p(i == 2), .c(i != 2), .en(pd_en[i]), .aa(16'h0200));
			cyc();
			cyc();
			chk("pdown", 1, powerdown_o);
		end
		cyc(.p(1'b0), .c(1'b0), .wr(6'h1f), .aa(16'h0300));
		cyc();
		chk("p_rd", 1, mem_rd_o);
		cyc();
		chk("p_nowr", 0, mem_wvalid_o);
		$display("test strobes done");
		// Each write code, then the word read back lane by lane
		for (int i = 0; i < 4; i++) begin
			wa = 16'h0400 + 16'(i);
			wd = 36'h5a1b2c3d4 ^ 36'(i);
			cyc(.c(1'b0), .wr(wr_t[i]), .aa(wa), .dd(wd));
			cyc();
			chk("c_rd", en_t[i] == 4'h0, mem_rd_o);
			cyc();
			if (en_t[i] != 4'h0) begin
				wait_sig(mem_wvalid_o, 1'b1);
				chk("wcmd", {en_t[i], wa, wd}, mem_wcmd_o);
			end
			cyc();
			rd_chk(wa, merge({4'ha, wa, wa}, wd, en_t[i]));
		end
		$display("test writes done");
		// Fill the buffer against a stalled array, then drain it
		@(posedge core_clk_i) stall <= 1'b1;
		n = 0;
		while (n < 24 && wbuf_ready_o === 1'b1) begin
			cyc(.c(1'b0), .wr(6'h1f), .aa(16'(n)));
			n++;
		end
		chk("full", 0, wbuf_ready_o);
		chk("depth", 1, n >= WBUF_DEPTH);
		@(posedge core_clk_i) stall <= 1'b0;
		wait_sig(mem_wvalid_o, 1'b0);
		cyc();
		chk("empty", 1, wbuf_ready_o);
		$display("test buffer done");
		report_and_stop();
	end
endmodule : testbench
